/* File: inc/lssel_pkg.sv */
// package of constants for the logic supply level select block
//
// Overview of operation
// (RULE_01) regulator reset: power-on high or reset pin low
// (RULE_02) regulator reset forces negative rail on logic supply
// (RULE_03) regulated level only when all selects zero
// (RULE_04) fast clock, low-select or converter force negative rail
// (RULE_05) reference rail lowered while converter enabled
// (RULE_06) logic supply switch closes on any select
// (RULE_07) control register is 4 bits at 38H
// (RULE_08) bits 3 to 1 read one, ignore writes
// (RULE_09) bit 0 low-select, cleared by system reset
// (RULE_10) low-select bit cannot block forced negative rail
// (RULE_11) selects reach regulator glitch-free from flip-flops
`default_nettype none
package lssel_pkg;
  localparam int unsigned       ADDR_W            = 12;
  localparam int unsigned       DATA_W            = 32;
  localparam logic [11:0]       CTRL_OFFSET       = 12'h038;
  localparam int unsigned       CTRL_WIDTH        = 4;
  localparam int unsigned       LOW_SEL_BIT       = 0;
  localparam logic [3:0]        CTRL_RSVD_READ    = 4'hE;
  localparam logic              LOW_SEL_RESET     = 1'b0;
  // rail select encodings toward the analogue regulator
  localparam logic              RAIL_REGULATED    = 1'b0;
  localparam logic              RAIL_NEGATIVE     = 1'b1;
  localparam logic              REF_POSITIVE      = 1'b0;
  localparam logic              REF_LOWERED       = 1'b1;
endpackage
`default_nettype wire

/* File: src/lssel_top.sv */
// logic supply level select: apb control register and regulator selects
//
// Our own choice: register access over APB.
`default_nettype none
module lssel_top
  import lssel_pkg::*;
(
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  // apb slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [lssel_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [lssel_pkg::DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]                  i_pstrb,
  output logic      [lssel_pkg::DATA_W-1:0] o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // select sources from pins and other blocks
  input  wire logic                        i_power_on_detect,
  input  wire logic                        i_reset_pin_n,
  input  wire logic                        i_fast_clock_select,
  input  wire logic                        i_converter_enable,
  // toward the analogue regulator
  output logic                             o_regulator_reset,
  output logic                             o_logic_supply_rail,
  output logic                             o_converter_reference_rail,
  output logic                             o_logic_supply_switch
);
  import lssel_pkg::*;

  // source order: power-on detect, reset pin (active low), fast clock, converter
  localparam int unsigned      SRC_N     = 4;
  // power-on assumed present until the pin level is seen, so rails start safe
  localparam logic [SRC_N-1:0] SRC_RESET = 4'h1;

  logic             logic_supply_low_select;
  logic [SRC_N-1:0] src_raw;
  logic [SRC_N-1:0] src_q;
  logic       por_q;
  logic       pin_n_q;
  logic       fclk_q;
  logic       adc_q;
  logic       acc;
  logic       hit;
  logic       next_regulator_reset;
  logic       next_rail;

  assign src_raw = {i_converter_enable, i_fast_clock_select, i_reset_pin_n, i_power_on_detect};

  // sources may come from other domains: three stages, change accepted when last two agree
  generate
    for (genvar g = 0; g < SRC_N; g++) begin : g_sync
      logic [2:0] stage;
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          stage    <= {3{SRC_RESET[g]}};
          src_q[g] <= SRC_RESET[g];
        end else begin
          stage <= {stage[1:0], src_raw[g]};
          if (stage[1] == stage[2]) begin
            src_q[g] <= stage[2];
          end
        end
      end
    end
  endgenerate

  assign por_q   = src_q[0];
  assign pin_n_q = src_q[1];
  assign fclk_q  = src_q[2];
  assign adc_q   = src_q[3];

  assign acc = i_psel && i_penable;
  assign hit = (i_paddr == CTRL_OFFSET);

  // control register: only bit 0 is storage, reserved bits ignore writes
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      logic_supply_low_select <= LOW_SEL_RESET;  // see (RULE_09)
    end else if (acc && i_pwrite && hit && i_pstrb[0]) begin
      logic_supply_low_select <= i_pwdata[LOW_SEL_BIT];  // see (RULE_07) see (RULE_08)
    end
  end

  // apb answers in the first access cycle; unmapped reads give zero with pslverr
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit;
      if (i_psel && !i_penable && !i_pwrite && hit) begin
        o_prdata <= {{(DATA_W-CTRL_WIDTH){1'b0}},
                     CTRL_RSVD_READ | {3'h0, logic_supply_low_select}};  // see (RULE_08)
      end else begin
        o_prdata <= '0;
      end
    end
  end

  always_comb begin
    next_regulator_reset = por_q || !pin_n_q;  // see (RULE_01)
    // the low-select bit can only add reasons for the negative rail
    if (next_regulator_reset || fclk_q || logic_supply_low_select || adc_q) begin
      next_rail = RAIL_NEGATIVE;  // see (RULE_02) see (RULE_04) see (RULE_10)
    end else begin
      next_rail = RAIL_REGULATED;  // see (RULE_03)
    end
  end

  // registered so the analogue selects never glitch on decode hazards
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_regulator_reset          <= 1'b1;
      o_logic_supply_rail        <= RAIL_NEGATIVE;
      o_converter_reference_rail <= REF_POSITIVE;
      o_logic_supply_switch      <= 1'b1;
    end else begin
      o_regulator_reset          <= next_regulator_reset;  // see (RULE_11)
      o_logic_supply_rail        <= next_rail;  // see (RULE_11)
      o_converter_reference_rail <= adc_q ? REF_LOWERED : REF_POSITIVE;  // see (RULE_05)
      o_logic_supply_switch      <= (next_rail == RAIL_NEGATIVE);  // see (RULE_06)
    end
  end
endmodule
`default_nettype wire

/* File: testbench/lssel_props.sv */
// port checker for the logic supply level select block
`default_nettype none
module lssel_props
  import lssel_pkg::*;
(
  // clock and reset
  input wire logic                         i_clk_sys,
  input wire logic                         i_nrst,
  // apb
  input wire logic                         i_pwrite,
  input wire logic                         i_penable,
  input wire logic [lssel_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [lssel_pkg::DATA_W-1:0] o_prdata,
  input wire logic                         o_pready,
  input wire logic                         o_pslverr,
  // select sources
  input wire logic                         i_power_on_detect,
  input wire logic                         i_reset_pin_n,
  input wire logic                         i_fast_clock_select,
  input wire logic                         i_converter_enable,
  // regulator selects
  input wire logic                         o_regulator_reset,
  input wire logic                         o_logic_supply_rail,
  input wire logic                         o_converter_reference_rail,
  input wire logic                         o_logic_supply_switch
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // seven samples cover the synchroniser latency
  wire logic rs = i_power_on_detect || !i_reset_pin_n;
  a_rst_on: assert property (rs [*7] |-> o_regulator_reset) else $error("no reset");
  a_rst_off: assert property (!rs [*7] |-> !o_regulator_reset) else $error("reset");
  a_rst_rail: assert property (o_regulator_reset |-> o_logic_supply_rail) else $error("rr");
  a_fast_rail: assert property (i_fast_clock_select [*7] |-> o_logic_supply_rail)
    else $error("fast rail");
  a_conv_ref: assert property (i_converter_enable [*7] |-> o_converter_reference_rail
    && o_logic_supply_rail) else $error("conv ref");
  a_ref_off: assert property (!i_converter_enable [*7] |-> !o_converter_reference_rail)
    else $error("ref off");
  a_switch_rail: assert property (o_logic_supply_switch == o_logic_supply_rail)
    else $error("switch");
  a_err_addr: assert property (o_pready |-> i_penable &&
    o_pslverr == (i_paddr != CTRL_OFFSET)) else $error("slverr");
  a_rsvd_one: assert property (o_pready && !i_pwrite && !o_pslverr |-> o_prdata[3:1] == 3'h7)
    else $error("reserved");
  c_err: cover property (o_pready && o_pslverr);
  c_wr: cover property (o_pready && i_pwrite);
  c_reg: cover property ($fell(o_logic_supply_rail));
endmodule
bind lssel_top lssel_props u_props (.i_clk_sys, .i_nrst, .i_pwrite, .i_penable, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .i_power_on_detect, .i_reset_pin_n, .i_fast_clock_select,
  .i_converter_enable, .o_regulator_reset, .o_logic_supply_rail, .o_converter_reference_rail,
  .o_logic_supply_switch);
`default_nettype wire

/* File: testbench/lssel_reg_model.sv */
// regulator model: rail levels in mV relative to the positive supply
`default_nettype none
module lssel_reg_model (
  // selects from the block
  input  wire logic i_rail,
  input  wire logic i_ref,
  // resulting levels
  output var int    o_logic_mv,
  output var int    o_ref_mv
);
  timeunit 1ns; timeprecision 1ps;
  assign o_logic_mv = i_rail ? -3000 : -1500;
  assign o_ref_mv = i_ref ? -1200 : 0;
endmodule
`default_nettype wire

/* File: testbench/lssel_top_tb.sv */
// testbench for the logic supply level select block
`default_nettype none
module lssel_top_tb;
  import lssel_pkg::*;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 0, nrst = 0, sel = 0, en = 0, wr = 0, rdy, err, perr, rrst, rail, rf, sw;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, r;
  logic [3:0] src = 0;
  int mismatches = 0, checked = 0, lmv, rmv;
  lssel_top u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(sel), .i_penable(en), .i_pwrite(wr),
    .i_paddr(adr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(rd), .o_pready(rdy),
    .o_pslverr(perr), .i_power_on_detect(src[0]), .i_reset_pin_n(~src[1]),
    .i_fast_clock_select(src[2]), .i_converter_enable(src[3]), .o_regulator_reset(rrst),
    .o_logic_supply_rail(rail), .o_converter_reference_rail(rf), .o_logic_supply_switch(sw));
  lssel_reg_model u_reg (.i_rail(rail), .i_ref(rf), .o_logic_mv(lmv), .o_ref_mv(rmv));
  initial forever #25 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); sel <= 1; wr <= w; adr <= a; wd <= d;
    @(posedge clk); en <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd; err = perr; sel <= 0; en <= 0;
  endtask
  task t_sources;
    for (int i = 0; i < 4; i++) begin
      src <= 4'h1 << i; repeat (8) @(posedge clk);
      chk("rail", 1, rail); chk("switch", 1, sw);
      chk("rst", i < 2, rrst); chk("ref", i == 3, rf);
    end
    src <= 0; repeat (8) @(posedge clk);
    chk("mv", -1500, lmv); chk("sw0", 0, sw); chk("ref0", 0, rmv);
  endtask
  task t_reg;
    apb(0, CTRL_OFFSET, 0); chk("init", 32'hE, r);
    apb(1, CTRL_OFFSET, 32'h1); repeat (3) @(posedge clk); chk("low", 1, rail);
    apb(0, CTRL_OFFSET, 0); chk("rdback", 32'hF, r);
    nrst <= 0; repeat (4) @(posedge clk); nrst <= 1; repeat (8) @(posedge clk);
    apb(0, CTRL_OFFSET, 0); chk("rstclr", 32'hE, r);
    apb(1, CTRL_OFFSET, 32'h0); repeat (3) @(posedge clk); chk("reg", 0, rail);
    apb(0, 12'h03C, 0); chk("unmap", 32'h1, {r[30:0], err});
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1; repeat (8) @(posedge clk);
    t_sources; t_reg; results;
  end
  initial begin #100us; mismatches++; results; end
endmodule
`default_nettype wire
